/* shared/ebt_pkg.sv */
// constants, register map and field layout of the eight-bit timer with shared divider
package ebt_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [9:0]  IDX_TICK_COUNT   = 10'h001;
   localparam logic [9:0]  IDX_IRQ_CONTROL  = 10'h00B;
   localparam logic [9:0]  IDX_PRESCALE_CFG = 10'h081;
   localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h090;
   localparam logic [9:0]  IDX_IRQ_MASK     = 10'h091;

   // interrupt_control field positions
   localparam int          GIE_BIT          = 7;
   localparam int          OVF_IE_BIT       = 5;
   localparam int          OVF_FLAG_BIT     = 2;
   // irq_status / irq_mask field positions
   localparam int          ST_OVF_BIT       = 0;

   // reset values and counter maximum
   localparam logic [7:0]  TICK_RST         = 8'h00;
   localparam logic [7:0]  IRQCTL_RST       = 8'h00;
   localparam logic [7:0]  CFG_RST          = 8'hFF;
   localparam logic [7:0]  MASK_RST         = 8'h00;
   localparam logic [7:0]  TICK_MAX         = 8'hFF;

   // timing: one instruction cycle is four pclk phases
   localparam int          CLK_MHZ          = 125;
   localparam int          PHASES_PER_INSTR = 4;
   localparam logic [1:0]  PHASE_TWO        = 2'h1;
   localparam logic [1:0]  PHASE_FOUR       = 2'h3;
   localparam int          WR_INHIBIT_INSTR = 2;
   localparam logic [1:0]  WR_INHIBIT_CNT   = 2'(WR_INHIBIT_INSTR);

   // configuration register layout
   typedef struct packed {
      logic [1:0] port_ctl;          // held for the port logic, no effect here
      logic       count_source_select;
      logic       count_edge_select;
      logic       divider_assign;
      logic [2:0] divider_ratio;
   } ebt_cfg_type;

   // apb request as seen by the slave
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ebt_apb_req_type;
endpackage

/* verilog/ebt_timer.sv */
// eight-bit timer/counter with a divider shared with the watchdog, apb register slave
//
// Register access over APB was decided locally.
`timescale 1ns/10ps

// Operation
// [RULE1] source bit picks pin edges or instruction cycles
// [RULE2] timer mode counts every instruction cycle
// [RULE3] counter write blocks counting two instruction cycles
// [RULE4] edge bit zero rising, one falling
// [RULE5] wrap from max to zero sets flag
// [RULE6] enable bit masks interrupt, flag still sets
// [RULE7] flag stays set until software clears it
// [RULE8] counting halts during sleep, no wake
// [RULE9] pin path sampled on phases two, four
// [RULE10] unassigned divider: pin feeds sampler directly
// [RULE11] divider serves one unit, other undivided
// [RULE12] divider count hidden from software access
// [RULE13] assign bit: one watchdog, zero timer
// [RULE14] timer ratio 2..256, watchdog 1..128
// [RULE15] counter write clears divider when timer owns
// [RULE16] watchdog clear clears divider when watchdog owns
// [RULE17] software uses safe sequence reassigning divider
// [RULE18] request needs flag, enable and global enable
module ebt_timer
   import ebt_pkg::*;
(
   input  wire logic        pclk,                 // bus and core clock
   input  wire logic        presetn,              // async reset, active low
   input  wire logic        ce,                   // clock enable, freezes all state
   input  wire logic        psel,                 // apb select
   input  wire logic        penable,              // apb enable
   input  wire logic        pwrite,               // apb direction
   input  wire logic [11:0] paddr,                // apb byte address
   input  wire logic [31:0] pwdata,               // apb write data
   output logic      [31:0] prdata,               // apb read data
   output logic             pready,               // apb ready
   output logic             pslverr,              // apb error, unmapped address
   input  wire logic        ext_count_input,      // external count pin
   input  wire logic        sleep_mode,           // core asleep
   input  wire logic        watchdog_tick,        // watchdog base clock pulse
   input  wire logic        watchdog_clear_instr, // watchdog clear executed
   output logic             watchdog_tick_out,    // divided watchdog pulse
   output logic             irq                   // level interrupt request
);

   ebt_apb_req_type req;
   logic [7:0]  tick_count_ff;
   logic [7:0]  irq_control_ff;
   ebt_cfg_type cfg_ff;
   logic [7:0]  irq_status_ff;
   logic [7:0]  irq_mask_ff;
   logic [7:0]  presc_ff;
   logic [1:0]  phase_ff;
   logic [1:0]  inhibit_ff;
   logic        raw_prev_ff;
   logic        sample_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        wdt_out_ff;
   logic        irq_ff;

   // sampler and edge detector start at the level an idle low pin gives under the reset edge select
   localparam ebt_cfg_type CFG_RST_F = CFG_RST;
   localparam logic        LEVEL_RST = CFG_RST_F.count_edge_select;

   function automatic logic ratio_hit(input logic [7:0] cnt, input logic [3:0] nbits);
      logic [8:0] mask;
      mask = (9'h001 << nbits) - 9'h001;
      return (cnt & mask[7:0]) == mask[7:0];
   endfunction

   function automatic logic addr_ok(input logic [11:0] a, input logic [9:0] idx);
      return a == {idx, 2'b00};
   endfunction

   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   logic take;
   logic wr_take;
   logic rd_take;
   logic wr_tick;
   logic wr_irqctl;
   logic instr_tick;
   logic raw_level;
   logic raw_rise;
   logic timer_owns;
   logic presc_step;
   logic presc_out;
   logic sample_slot;
   logic count_evt;
   logic inc;
   logic overflow;
   logic mapped;

   assign take       = req.sel && req.enable && pready_ff;
   assign wr_take    = take && req.write;
   assign rd_take    = take && !req.write;
   assign wr_tick    = wr_take && addr_ok(req.addr, IDX_TICK_COUNT);
   assign wr_irqctl  = wr_take && addr_ok(req.addr, IDX_IRQ_CONTROL);
   assign mapped     = addr_ok(req.addr, IDX_TICK_COUNT) || addr_ok(req.addr, IDX_IRQ_CONTROL)
                       || addr_ok(req.addr, IDX_PRESCALE_CFG) || addr_ok(req.addr, IDX_IRQ_STATUS)
                       || addr_ok(req.addr, IDX_IRQ_MASK);
   assign instr_tick = phase_ff == PHASE_FOUR;
   assign timer_owns = !cfg_ff.divider_assign;                      // see [RULE13] [RULE11]
   // edge select inverts the pin so that the chosen edge is always a rise
   assign raw_level  = ext_count_input ^ cfg_ff.count_edge_select;  // see [RULE4]
   assign raw_rise   = raw_level && !raw_prev_ff;

   // divider input: instruction cycles or pin edges for the timer, base ticks for the watchdog
   always_comb begin
      if (timer_owns) begin
         presc_step = cfg_ff.count_source_select ? raw_rise : instr_tick;
      end else begin
         presc_step = watchdog_tick;
      end
   end

   // bypass when the watchdog owns the divider
   assign presc_out   = timer_owns ? presc_ff[cfg_ff.divider_ratio] : raw_level; // see [RULE10]
   assign sample_slot = (phase_ff == PHASE_TWO) || (phase_ff == PHASE_FOUR);

   always_comb begin
      if (cfg_ff.count_source_select) begin
         count_evt = sample_slot && presc_out && !sample_ff;    // see [RULE1] [RULE9]
      end else if (timer_owns) begin
         count_evt = instr_tick
                     && ratio_hit(presc_ff, {1'b0, cfg_ff.divider_ratio} + 4'h1); // see [RULE14]
      end else begin
         count_evt = instr_tick;                                                 // see [RULE2]
      end
   end

   // a write always wins over a same-cycle count; sleep stops the counter
   assign inc      = count_evt && !sleep_mode && (inhibit_ff == 2'h0)
                     && !wr_tick;                                   // see [RULE8] [RULE3]
   assign overflow = inc && (tick_count_ff == TICK_MAX);

   // instruction cycle phase generator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 2'h0;
      end else if (ce) begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   // pin edge detect and phase sampler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_prev_ff <= LEVEL_RST;
         sample_ff   <= LEVEL_RST;
      end else if (ce) begin
         raw_prev_ff <= raw_level;
         if (sample_slot && !sleep_mode) begin
            sample_ff <= presc_out;                                              // see [RULE9]
         end
      end
   end

   // shared divider; no bus path reads or loads it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= 8'h00;
      end else if (ce) begin
         if (wr_tick && timer_owns) begin
            presc_ff <= 8'h00;                                                   // see [RULE15]
         end else if (watchdog_clear_instr && !timer_owns) begin
            presc_ff <= 8'h00;                                                   // see [RULE16]
         end else if (presc_step && (!timer_owns || !sleep_mode)) begin
            presc_ff <= presc_ff + 8'h01;                                        // see [RULE12]
         end
      end
   end

   // watchdog side: undivided while the timer owns the divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_out_ff <= 1'b0;
      end else if (ce) begin
         if (timer_owns) begin
            wdt_out_ff <= watchdog_tick;                                         // see [RULE11]
         end else begin
            wdt_out_ff <= watchdog_tick && !watchdog_clear_instr
                          && ratio_hit(presc_ff, {1'b0, cfg_ff.divider_ratio}); // see [RULE14]
         end
      end
   end

   // write inhibit counted in instruction cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inhibit_ff <= 2'h0;
      end else if (ce) begin
         if (wr_tick) begin
            inhibit_ff <= WR_INHIBIT_CNT;                                        // see [RULE3]
         end else if (instr_tick && (inhibit_ff != 2'h0)) begin
            inhibit_ff <= inhibit_ff - 2'h1;
         end
      end
   end

   // tick counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_count_ff <= TICK_RST;
      end else if (ce) begin
         if (wr_tick) begin
            tick_count_ff <= req.wdata[7:0];
         end else if (inc) begin
            tick_count_ff <= tick_count_ff + 8'h01;                              // see [RULE2]
         end
      end
   end

   // interrupt control; a wrap in the same cycle as a software clear keeps the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_control_ff <= IRQCTL_RST;
      end else if (ce) begin
         if (wr_irqctl) begin
            irq_control_ff[GIE_BIT]    <= req.wdata[GIE_BIT];
            irq_control_ff[OVF_IE_BIT] <= req.wdata[OVF_IE_BIT];
         end
         if (overflow) begin
            irq_control_ff[OVF_FLAG_BIT] <= 1'b1;                    // see [RULE5] [RULE6]
         end else if (wr_irqctl) begin
            irq_control_ff[OVF_FLAG_BIT] <= req.wdata[OVF_FLAG_BIT];             // see [RULE7]
         end
      end
   end

   // configuration and interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff      <= CFG_RST;
         irq_mask_ff <= MASK_RST;
      end else if (ce && wr_take) begin
         if (addr_ok(req.addr, IDX_PRESCALE_CFG)) begin
            cfg_ff <= req.wdata[7:0];                                            // see [RULE13]
         end
         if (addr_ok(req.addr, IDX_IRQ_MASK)) begin
            irq_mask_ff <= {7'h00, req.wdata[ST_OVF_BIT]};
         end
      end
   end

   // sticky status, cleared by a read; a new event wins over that read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_ff <= 8'h00;
      end else if (ce) begin
         if (overflow) begin
            irq_status_ff[ST_OVF_BIT] <= 1'b1;
         end else if (rd_take && addr_ok(req.addr, IDX_IRQ_STATUS)) begin
            irq_status_ff[ST_OVF_BIT] <= 1'b0;
         end
      end
   end

   // interrupt output registered; sleep does not gate it, so a flag set before sleep still raises it while asleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else if (ce) begin
         irq_ff <= irq_control_ff[GIE_BIT] && irq_control_ff[OVF_IE_BIT]
                   && irq_control_ff[OVF_FLAG_BIT]
                   && irq_status_ff[ST_OVF_BIT] && irq_mask_ff[ST_OVF_BIT]; // see [RULE18] [RULE6]
      end
   end

   // apb slave: one wait state, ready and data both from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (ce) begin
         pready_ff  <= req.sel && req.enable && !pready_ff;
         pslverr_ff <= req.sel && req.enable && !pready_ff && !mapped;
         prdata_ff  <= 32'h0000_0000;
         if (req.sel && req.enable && !pready_ff && !req.write) begin
            unique case (1'b1)
               addr_ok(req.addr, IDX_TICK_COUNT):   prdata_ff[7:0] <= tick_count_ff;
               addr_ok(req.addr, IDX_IRQ_CONTROL):  prdata_ff[7:0] <= irq_control_ff;
               addr_ok(req.addr, IDX_PRESCALE_CFG): prdata_ff[7:0] <= cfg_ff;
               addr_ok(req.addr, IDX_IRQ_STATUS):   prdata_ff[7:0] <= irq_status_ff;
               addr_ok(req.addr, IDX_IRQ_MASK):     prdata_ff[7:0] <= irq_mask_ff;
               default:                             prdata_ff[7:0] <= 8'h00;
            endcase
         end
      end
   end

   assign prdata            = prdata_ff;
   assign pready            = pready_ff;
   assign pslverr           = pslverr_ff;
   assign watchdog_tick_out = wdt_out_ff;
   assign irq               = irq_ff;

   // assertion helpers
   sequence tick_write_s;
      ce && wr_tick;
   endsequence

   sequence quiet_instr_s;
      (!inc) [*8];
   endsequence

   write_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
      tick_write_s |=> quiet_instr_s)
      else $error("count advanced inside the write inhibit");

   overflow_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE5]
      (ce && overflow) |=> irq_control_ff[OVF_FLAG_BIT] && tick_count_ff == 8'h00)
      else $error("wrap did not set the overflow flag");

   flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)   // see [RULE7]
      (irq_control_ff[OVF_FLAG_BIT] && !wr_irqctl) |=> irq_control_ff[OVF_FLAG_BIT])
      else $error("overflow flag dropped without software");

   sleep_halt_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RULE8]
      (ce && sleep_mode && !wr_tick) |=> $stable(tick_count_ff))
      else $error("counter moved during sleep");

   presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)   // see [RULE15]
      (ce && wr_tick && timer_owns) |=> presc_ff == 8'h00)
      else $error("counter write left divider uncleared");

   wdt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)     // see [RULE16]
      (ce && watchdog_clear_instr && !timer_owns) |=> presc_ff == 8'h00)
      else $error("watchdog clear left divider uncleared");

   irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)      // see [RULE18]
      irq |-> $past(irq_control_ff[GIE_BIT] && irq_control_ff[OVF_IE_BIT]
                    && irq_control_ff[OVF_FLAG_BIT]))
      else $error("interrupt raised without all enables");

   timer_step_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RULE2]
      (ce && !cfg_ff.count_source_select && !timer_owns && instr_tick && !sleep_mode
       && inhibit_ff == 2'h0 && !wr_tick)
      |=> tick_count_ff == $past(tick_count_ff) + 8'h01)
      else $error("undivided timer missed an instruction cycle");

   sample_phase_a: assert property (@(posedge pclk) disable iff (!presetn)  // see [RULE9]
      (ce && cfg_ff.count_source_select && inc) |-> sample_slot)
      else $error("pin count outside sampling phases");

   wdt_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)    // see [RULE11]
      (ce && timer_owns) |=> watchdog_tick_out == $past(watchdog_tick))
      else $error("watchdog divided while timer owns divider");

endmodule

/* verilog/ebt_unused_placeholder_removed.sv */
// intentionally empty design unit list terminator
`timescale 1ns/10ps

/* bench/tb_ebt_timer.sv */
// self-checking bench for the eight-bit timer with shared divider
`timescale 1ns/10ps
module tb_ebt_timer
   import ebt_pkg::*;
;
   typedef struct packed {
      logic [31:0] d;
      logic        er;
      logic        rd;
   } ebt_note_type;

   localparam logic [11:0] A_TICK = {IDX_TICK_COUNT, 2'b00};
   localparam logic [11:0] A_CTL  = {IDX_IRQ_CONTROL, 2'b00};
   localparam logic [11:0] A_CFG  = {IDX_PRESCALE_CFG, 2'b00};
   localparam logic [11:0] A_ST   = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
   localparam logic [11:0] A_BAD  = 12'hFFC;

   logic         pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata;
   logic         ext_count_input, sleep_mode, watchdog_tick, watchdog_clear_instr;
   logic         watchdog_tick_out;
   ebt_note_type q[$];
   ebt_note_type nt;
   int           fails, n_tests, cyc, wdc, n, w0, k;
   logic [7:0]   rnd, t;

   ebt_timer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_count_input(ext_count_input), .sleep_mode(sleep_mode),
      .watchdog_tick(watchdog_tick), .watchdog_clear_instr(watchdog_clear_instr),
      .watchdog_tick_out(watchdog_tick_out), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rng(input string nm, input int v, input int lo, input int hi);
      chk(nm, (v >= lo && v <= hi) ? 32'h1 : 32'h0, 32'h1);
   endtask

   // the note goes on the queue before the request, the monitor pops it at completion
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] ex, input logic er);
      q.push_back('{ex, er, !wr});
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic meas(output int m);
      m = 0;
      while (irq !== 1'b1 && m < 300) begin
         @(posedge pclk);
         m++;
      end
   endtask

   task automatic pin_pulses(input int c);
      repeat (c) begin
         ext_count_input <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_count_input <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask

   task automatic wd_pulses(input int c);
      repeat (c) begin
         watchdog_tick <= 1'b1;
         @(posedge pclk);
         watchdog_tick <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && q.size() > 0) begin
         nt = q.pop_front();
         chk("pslverr", {31'h0, pslverr}, {31'h0, nt.er});
         if (nt.rd) chk("prdata", prdata, nt.d);
      end
      if (watchdog_tick_out === 1'b1) wdc++;
      cyc++;
      if (cyc == 30000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, ext_count_input, sleep_mode} = '0;
      {watchdog_tick, watchdog_clear_instr, paddr, pwdata} = '0;
      ce = 1'b1;
      rnd = 8'd86;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, A_TICK, 0, 32'h0, 0);
      apb(0, A_CTL, 0, 32'h0, 0);
      apb(0, A_CFG, 0, 32'hFF, 0);
      apb(0, A_ST, 0, 32'h0, 0);
      apb(0, A_MASK, 0, 32'h0, 0);
      apb(1, A_BAD, 32'h55, 32'h0, 1);
      apb(0, A_BAD, 0, 32'h0, 1);
      $display("test reset_values done");
      apb(1, A_MASK, 1, 0, 0);
      apb(1, A_CTL, 32'hA0, 0, 0);
      apb(1, A_CFG, 32'h08, 0, 0);
      apb(1, A_TICK, 32'hFF, 0, 0);
      meas(n);
      rng("ovf_time_undivided", n, 10, 13);
      apb(0, A_CTL, 0, 32'hA4, 0);
      apb(0, A_ST, 0, 32'h01, 0);
      repeat (2) @(posedge pclk);
      chk("irq_after_status_read", {31'h0, irq}, 32'h0);
      apb(0, A_ST, 0, 32'h00, 0);
      apb(1, A_CTL, 32'h80, 0, 0);
      apb(1, A_TICK, 32'hFF, 0, 0);
      repeat (40) @(posedge pclk);
      chk("irq_enable_off", {31'h0, irq}, 32'h0);
      apb(0, A_CTL, 0, 32'h84, 0);
      repeat (20) @(posedge pclk);
      apb(0, A_CTL, 0, 32'h84, 0);
      apb(1, A_CTL, 32'h24, 0, 0);
      apb(1, A_TICK, 32'hFF, 0, 0);
      repeat (40) @(posedge pclk);
      chk("irq_global_off", {31'h0, irq}, 32'h0);
      apb(1, A_CTL, 32'hA4, 0, 0);
      repeat (3) @(posedge pclk);
      chk("irq_all_on", {31'h0, irq}, 32'h1);
      apb(1, A_MASK, 0, 0, 0);
      repeat (3) @(posedge pclk);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      apb(1, A_MASK, 1, 0, 0);
      apb(0, A_ST, 0, 32'h01, 0);
      apb(1, A_CTL, 32'hA0, 0, 0);
      $display("test interrupt done");
      for (int r = 1; r < 4; r++) begin
         apb(1, A_CFG, r, 0, 0);
         apb(1, A_TICK, 32'hFF, 0, 0);
         meas(n);
         rng("ovf_time_divided", n, (8 << r) - 2, (8 << r) + 1);
         apb(0, A_ST, 0, 32'h01, 0);
         apb(1, A_CTL, 32'hA0, 0, 0);
      end
      $display("test timer_divider done");
      apb(1, A_CFG, 32'h08, 0, 0);
      sleep_mode <= 1'b1;
      apb(1, A_TICK, 32'h40, 0, 0);
      repeat (40) @(posedge pclk);
      apb(0, A_TICK, 0, 32'h40, 0);
      sleep_mode <= 1'b0;
      // a low clock enable must hold the counter and its write inhibit
      apb(1, A_TICK, 32'h10, 0, 0);
      ce <= 1'b0;
      repeat (40) @(posedge pclk);
      ce <= 1'b1;
      apb(0, A_TICK, 0, 32'h10, 0);
      $display("test sleep done");
      for (int e = 0; e < 2; e++) begin
         rnd = lfsr(rnd);
         t = rnd & 8'h7F;
         rnd = lfsr(rnd);
         k = 1 + (rnd & 8'h07);
         apb(1, A_CFG, 32'h28 | (e << 4), 0, 0);
         apb(1, A_TICK, t, 0, 0);
         repeat (16) @(posedge pclk);
         pin_pulses(k);
         ext_count_input <= 1'b1;
         repeat (8) @(posedge pclk);
         apb(0, A_TICK, 0, 32'(t + k + 1 - e), 0);
         ext_count_input <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      apb(1, A_CFG, 32'h20, 0, 0);
      apb(1, A_TICK, 32'h00, 0, 0);
      repeat (16) @(posedge pclk);
      pin_pulses(6);
      repeat (8) @(posedge pclk);
      apb(0, A_TICK, 0, 32'h03, 0);
      $display("test counter_mode done");
      // move the divider to the watchdog only from a cleared divider
      apb(1, A_TICK, 32'h00, 0, 0);
      apb(1, A_CFG, 32'h0A, 0, 0);
      watchdog_clear_instr <= 1'b1;
      @(posedge pclk);
      watchdog_clear_instr <= 1'b0;
      repeat (3) @(posedge pclk);
      w0 = wdc;
      wd_pulses(8);
      chk("wd_div4", wdc - w0, 32'h2);
      w0 = wdc;
      wd_pulses(3);
      watchdog_clear_instr <= 1'b1;
      @(posedge pclk);
      watchdog_clear_instr <= 1'b0;
      repeat (3) @(posedge pclk);
      wd_pulses(5);
      chk("wd_clear", wdc - w0, 32'h1);
      apb(1, A_CFG, 32'h08, 0, 0);
      w0 = wdc;
      wd_pulses(3);
      chk("wd_div1", wdc - w0, 32'h3);
      apb(1, A_CFG, 32'h07, 0, 0);
      w0 = wdc;
      wd_pulses(3);
      chk("wd_undivided", wdc - w0, 32'h3);
      $display("test watchdog_divider done");
      wrap_up();
   end
endmodule
